/* File: src/bfp_pkg.sv */
// Function
// - pick-up when any phase exceeds phase threshold or residual exceeds residual threshold
// - pick-up releases only below 97 percent of the threshold
// - one phase threshold serves all three phases alike
// - residual source: none, first input, second input or computed; default none
// - start criterion combines current, output relay and signals; default current only
// - phase threshold in 0.01 nominal steps up to 40, default 0.20
// - residual threshold in 0.001 nominal steps up to 40, default 1.200; the register takes values up to 65.535
// - blocking input sampled at the beginning of every program cycle
// - pick-up without blocking asserts start and begins delay timing
// - pick-up with blocking asserts blocked and does no further processing
// - blocking during start drops start and releases like pick-up drop
// - retrip and breaker-failure timers start together from one pick-up
// - retrip enable setting, default enabled; disabled suppresses retrip output
// - retrip output after start persists retrip delay; 5 ms steps, default 100 ms
// - failure output after start persists failure delay; 5 ms steps, default 200 ms
// - readable condition: normal, start, retrip, failure, on, blocked
// - readable behaviour: on, blocked, test, test-and-blocked, off
// - current-only criterion clears both counters when current drops below 97 percent of threshold
// - current-and-output criterion halts counters until monitored relay energizes
// - comparison inputs are fundamental magnitudes updated every 5 ms
package bfp_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_CYCLE_NS = 5000000;
  localparam int unsigned PROG_CYCLE_CLKS = PROG_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_LEAD_NS = 5000000;
  localparam int unsigned STEP_MS = 5;
  localparam int unsigned RT_DLY_DEF_MS = 100;
  localparam int unsigned BF_DLY_DEF_MS = 200;

  // ***************************************************************
  // widths and scaling
  // ***************************************************************
  localparam int unsigned MAG_W = 16;
  localparam int unsigned CNT_W = 19;
  localparam logic [23:0] RESET_PCT = 24'h000061;
  localparam logic [23:0] FULL_PCT = 24'h000064;
  localparam logic [15:0] PH_SCALE = 16'h000A;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PH_THR = 8'h04;
  localparam logic [7:0] ADR_RES_THR = 8'h08;
  localparam logic [7:0] ADR_RT_DLY = 8'h0C;
  localparam logic [7:0] ADR_BF_DLY = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam int unsigned CTRL_RES_LSB = 0;
  localparam int unsigned CTRL_CRIT_LSB = 2;
  localparam int unsigned CTRL_RTEN_BIT = 6;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam int unsigned STS_COND_LSB = 0;
  localparam int unsigned STS_BEH_LSB = 4;
  localparam int unsigned STS_START_BIT = 8;
  localparam int unsigned STS_RT_BIT = 9;
  localparam int unsigned STS_BF_BIT = 10;
  localparam int unsigned STS_BLK_BIT = 11;
  localparam int unsigned STS_PICK_BIT = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000077F;
  localparam logic [31:0] PH_THR_MASK = 32'h00000FFF;
  localparam logic [31:0] RES_THR_MASK = 32'h0000FFFF;
  localparam logic [31:0] DLY_MASK = 32'h0007FFFF;
  localparam logic [31:0] CTRL_RST = 32'h00000040;
  localparam logic [31:0] PH_THR_RST = 32'h00000014;
  localparam logic [31:0] RES_THR_RST = 32'h000004B0;
  localparam logic [31:0] RT_DLY_RST = 32'(RT_DLY_DEF_MS / STEP_MS);
  localparam logic [31:0] BF_DLY_RST = 32'(BF_DLY_DEF_MS / STEP_MS);

  // ***************************************************************
  // enumerations
  // ***************************************************************
  typedef enum logic [1:0] {
    RES_NONE = 2'h0, RES_ONE = 2'h1, RES_TWO = 2'h2, RES_CALC = 2'h3
  } bfp_res_type;
  typedef enum logic [3:0] {
    CRIT_CUR = 4'h0, CRIT_DO = 4'h1, CRIT_SIG = 4'h2, CRIT_CUR_AND_DO = 4'h3,
    CRIT_CUR_AND_SIG = 4'h4, CRIT_CUR_OR_DO = 4'h5, CRIT_CUR_OR_SIG = 4'h6,
    CRIT_SIG_AND_DO = 4'h7, CRIT_SIG_OR_DO = 4'h8, CRIT_ALL_AND = 4'h9,
    CRIT_ALL_OR = 4'hA
  } bfp_crit_type;
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLK = 3'h3,
    MODE_OFF = 3'h4
  } bfp_mode_type;
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0, COND_START = 3'h1, COND_RETRIP = 3'h2, COND_FAIL = 3'h3,
    COND_ON = 3'h4, COND_BLOCKED = 3'h5
  } bfp_cond_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_START = 3'b010, ST_BLOCKED = 3'b100
  } bfp_state_type;

endpackage

/* File: src/bfp_tmr_if.sv */
`timescale 1ns/100ps
`default_nettype none
// timer control between the supervision core and one delay timer
interface bfp_tmr_if;
  logic tick;
  logic run;
  logic [bfp_pkg::CNT_W-1:0] delay;
  logic expired;
  modport ctl (output tick, output run, output delay, input expired);
  modport tmr (input tick, input run, input delay, output expired);
endinterface
`default_nettype wire

/* File: src/bfp_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module bfp_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  bfp_tmr_if.tmr t
);

  logic [bfp_pkg::CNT_W-1:0] cnt_r;
  logic [bfp_pkg::CNT_W-1:0] cnt_nxt;
  logic exp_r;

  // saturating count so a huge delay never wraps back to zero
  assign cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + 1'b1;
  assign t.expired = exp_r;

  // one step per program cycle, cleared at once when the run drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !t.run) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else if (t.tick) begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_r | (cnt_nxt >= t.delay);
    end
  end

  timer_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exp_r && t.run |=> exp_r) else $error("timer output dropped while running");

endmodule // bfp_timer
`default_nettype wire

/* File: src/bfp_pickup.sv */
`timescale 1ns/100ps
`default_nettype none
module bfp_pickup (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // program cycle strobe
  input wire logic tick_i,
  // magnitudes and thresholds, 0.001 nominal per lsb
  input wire logic [3:0][bfp_pkg::MAG_W-1:0] measured_magnitude_i,
  input wire logic [3:0][bfp_pkg::MAG_W-1:0] thr_i,
  input wire logic [3:0] en_i,
  // per channel pick-up
  output logic [3:0] act_o
);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      logic act_r;
      logic over;
      logic under;
      // products kept at 24 bits so 65.535 x 100 fits
      assign over = measured_magnitude_i[g] > thr_i[g];
      assign under = (24'(measured_magnitude_i[g]) * bfp_pkg::FULL_PCT) <
                     (24'(thr_i[g]) * bfp_pkg::RESET_PCT);
      // hysteresis evaluated once per program cycle only
      always_ff @(posedge clk_i) begin
        if (rst_i || !en_i[g]) begin
          act_r <= 1'b0;
        end else if (tick_i) begin
          if (!act_r && over) begin
            act_r <= 1'b1;
          end else if (act_r && under) begin
            act_r <= 1'b0;
          end
        end
      end
      assign act_o[g] = act_r;

      pick_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_i && en_i[g] && act_r && !under |=> act_r)
        else $error("pick-up released above reset level");
      pick_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_i && en_i[g] && over |=> act_r) else $error("pick-up missed");
    end
  endgenerate

endmodule // bfp_pickup
`default_nettype wire

/* File: src/bfp_top.sv */
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bfp_top #(
  parameter int unsigned CYCLE_CLKS = bfp_pkg::PROG_CYCLE_CLKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // measurements, 0.001 nominal per lsb
  input wire logic [2:0][bfp_pkg::MAG_W-1:0] phase_magnitude_i,
  input wire logic [bfp_pkg::MAG_W-1:0] residual_input_one_i,
  input wire logic [bfp_pkg::MAG_W-1:0] residual_input_two_i,
  input wire logic [bfp_pkg::MAG_W-1:0] computed_residual_i,
  // binary inputs
  input wire logic do_monitor_i,
  input wire logic signal_monitor_i,
  input wire logic block_i,
  // trip contacts and state
  output logic start_o,
  output logic blocked_o,
  output logic retrip_o,
  output logic breaker_failure_output_o
);

  // ***************************************************************
  // registers and bus slave
  // ***************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] phase_pickup_threshold_r;
  logic [31:0] residual_pickup_threshold_r;
  logic [31:0] second_coil_delay_setting_r;
  logic [31:0] fail_delay_r;
  logic [31:0] status;
  logic [31:0] rd_nxt;
  logic ack_r;
  logic [31:0] dat_r;
  logic wr_go;
  logic [7:0] adr;

  // byte enables and field mask together decide which bits change
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel, input logic [31:0] m);
    logic [31:0] bm;
    bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & m;
    merge = (old & ~bm) | (d & bm);
  endfunction

  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

  // configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= bfp_pkg::CTRL_RST;
      phase_pickup_threshold_r <= bfp_pkg::PH_THR_RST;
      residual_pickup_threshold_r <= bfp_pkg::RES_THR_RST;
      second_coil_delay_setting_r <= bfp_pkg::RT_DLY_RST;
      fail_delay_r <= bfp_pkg::BF_DLY_RST;
    end else if (wr_go) begin
      case (adr)
        bfp_pkg::ADR_CTRL: begin
          ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i, bfp_pkg::CTRL_MASK);
        end
        bfp_pkg::ADR_PH_THR: begin
          phase_pickup_threshold_r <= merge(phase_pickup_threshold_r, wb_dat_i, wb_sel_i,
                                            bfp_pkg::PH_THR_MASK);
        end
        bfp_pkg::ADR_RES_THR: begin
          residual_pickup_threshold_r <= merge(residual_pickup_threshold_r, wb_dat_i,
                                               wb_sel_i, bfp_pkg::RES_THR_MASK);
        end
        bfp_pkg::ADR_RT_DLY: begin
          second_coil_delay_setting_r <= merge(second_coil_delay_setting_r, wb_dat_i,
                                               wb_sel_i, bfp_pkg::DLY_MASK);
        end
        bfp_pkg::ADR_BF_DLY: begin
          fail_delay_r <= merge(fail_delay_r, wb_dat_i, wb_sel_i, bfp_pkg::DLY_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (adr)
      bfp_pkg::ADR_CTRL: rd_nxt = ctrl_r;
      bfp_pkg::ADR_PH_THR: rd_nxt = phase_pickup_threshold_r;
      bfp_pkg::ADR_RES_THR: rd_nxt = residual_pickup_threshold_r;
      bfp_pkg::ADR_RT_DLY: rd_nxt = second_coil_delay_setting_r;
      bfp_pkg::ADR_BF_DLY: rd_nxt = fail_delay_r;
      bfp_pkg::ADR_STATUS: rd_nxt = status;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // one wait state; ack falls the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      dat_r <= rd_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ***************************************************************
  // settings decode
  // ***************************************************************
  bfp_pkg::bfp_res_type residual_source_select;
  bfp_pkg::bfp_crit_type crit;
  bfp_pkg::bfp_mode_type function_node_mode;
  logic rt_en;
  logic eff_blk;
  logic node_off;
  logic test_mode;

  assign residual_source_select = bfp_pkg::bfp_res_type'(ctrl_r[bfp_pkg::CTRL_RES_LSB +: 2]);
  assign crit = bfp_pkg::bfp_crit_type'(ctrl_r[bfp_pkg::CTRL_CRIT_LSB +: 4]);
  assign function_node_mode = bfp_pkg::bfp_mode_type'(ctrl_r[bfp_pkg::CTRL_MODE_LSB +: 3]);
  assign rt_en = ctrl_r[bfp_pkg::CTRL_RTEN_BIT];
  // unknown mode codes behave as off, the safe side for a trip relay
  assign node_off = !(function_node_mode inside {bfp_pkg::MODE_ON, bfp_pkg::MODE_BLOCKED,
                      bfp_pkg::MODE_TEST, bfp_pkg::MODE_TEST_BLK});
  assign test_mode = function_node_mode inside {bfp_pkg::MODE_TEST, bfp_pkg::MODE_TEST_BLK};
  assign eff_blk = block_i || function_node_mode == bfp_pkg::MODE_BLOCKED ||
                   function_node_mode == bfp_pkg::MODE_TEST_BLK;

  // ***************************************************************
  // program cycle and pick-up
  // ***************************************************************
  logic [31:0] cyc_cnt_r;
  logic tick;
  logic [bfp_pkg::MAG_W-1:0] res_mag;
  logic [3:0][bfp_pkg::MAG_W-1:0] mags;
  logic [3:0][bfp_pkg::MAG_W-1:0] thrs;
  logic [3:0] pick_en;
  logic [3:0] act;
  logic pick;

  // free-running 5 ms strobe
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      cyc_cnt_r <= 32'h00000000;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
    end
  end
  assign tick = cyc_cnt_r == 32'(CYCLE_CLKS - 1);

  // residual source mux
  always_comb begin
    case (residual_source_select)
      bfp_pkg::RES_ONE: res_mag = residual_input_one_i;
      bfp_pkg::RES_TWO: res_mag = residual_input_two_i;
      bfp_pkg::RES_CALC: res_mag = computed_residual_i;
      default: res_mag = '0;
    endcase
  end

  // one scaled phase threshold feeds all three phase channels
  assign mags = {res_mag, phase_magnitude_i};
  assign thrs = {residual_pickup_threshold_r[15:0], {3{16'(phase_pickup_threshold_r[15:0] *
                 bfp_pkg::PH_SCALE)}}};
  assign pick_en = {residual_source_select != bfp_pkg::RES_NONE, 3'b111} &
                   {4{!node_off}};
  assign pick = |act;

  bfp_pickup u_pickup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .measured_magnitude_i(mags),
    .thr_i(thrs),
    .en_i(pick_en),
    .act_o(act)
  );

  // ***************************************************************
  // start criterion and supervision state
  // ***************************************************************
  logic cond;
  bfp_pkg::bfp_state_type state_r;
  bfp_pkg::bfp_state_type state_nxt;

  // and-forms hold the count back until every part is present
  always_comb begin
    case (crit)
      bfp_pkg::CRIT_CUR: cond = pick;
      bfp_pkg::CRIT_DO: cond = do_monitor_i;
      bfp_pkg::CRIT_SIG: cond = signal_monitor_i;
      bfp_pkg::CRIT_CUR_AND_DO: cond = pick && do_monitor_i;
      bfp_pkg::CRIT_CUR_AND_SIG: cond = pick && signal_monitor_i;
      bfp_pkg::CRIT_CUR_OR_DO: cond = pick || do_monitor_i;
      bfp_pkg::CRIT_CUR_OR_SIG: cond = pick || signal_monitor_i;
      bfp_pkg::CRIT_SIG_AND_DO: cond = signal_monitor_i && do_monitor_i;
      bfp_pkg::CRIT_SIG_OR_DO: cond = signal_monitor_i || do_monitor_i;
      bfp_pkg::CRIT_ALL_AND: cond = pick && do_monitor_i && signal_monitor_i;
      bfp_pkg::CRIT_ALL_OR: cond = pick || do_monitor_i || signal_monitor_i;
      default: cond = 1'b0;
    endcase
  end

  // block taken only at the program cycle boundary
  always_comb begin
    state_nxt = state_r;
    if (tick) begin
      case (state_r)
        bfp_pkg::ST_IDLE: begin
          if (cond && !node_off) begin
            state_nxt = eff_blk ? bfp_pkg::ST_BLOCKED : bfp_pkg::ST_START;
          end
        end
        bfp_pkg::ST_START: begin
          if (!cond || eff_blk || node_off) begin
            state_nxt = bfp_pkg::ST_IDLE;
          end
        end
        bfp_pkg::ST_BLOCKED: begin
          if (!cond || node_off) begin
            state_nxt = bfp_pkg::ST_IDLE;
          end
        end
        default: state_nxt = bfp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= bfp_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************************************
  // delay timers and outputs
  // ***************************************************************
  bfp_tmr_if rt_if ();
  bfp_tmr_if bf_if ();
  logic running;
  logic retrip_r;
  logic fail_r;

  // both timers share one run so they start on the same pick-up
  assign running = state_r == bfp_pkg::ST_START;
  assign rt_if.tick = tick;
  assign rt_if.run = running;
  assign rt_if.delay = second_coil_delay_setting_r[bfp_pkg::CNT_W-1:0];
  assign bf_if.tick = tick;
  assign bf_if.run = running;
  assign bf_if.delay = fail_delay_r[bfp_pkg::CNT_W-1:0];

  bfp_timer u_rt_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(rt_if.tmr)
  );

  bfp_timer u_bf_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(bf_if.tmr)
  );

  // test mode runs everything but keeps the contacts open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retrip_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      retrip_r <= rt_if.expired && rt_en && !test_mode;
      fail_r <= bf_if.expired && !test_mode;
    end
  end
  assign retrip_o = retrip_r;
  assign breaker_failure_output_o = fail_r;
  assign start_o = state_r == bfp_pkg::ST_START;
  assign blocked_o = state_r == bfp_pkg::ST_BLOCKED;

  // ***************************************************************
  // status
  // ***************************************************************
  bfp_pkg::bfp_cond_type cond_code;

  always_comb begin
    if (state_r == bfp_pkg::ST_BLOCKED) begin
      cond_code = bfp_pkg::COND_BLOCKED;
    end else if (bf_if.expired) begin
      cond_code = bfp_pkg::COND_FAIL;
    end else if (rt_if.expired && rt_en) begin
      cond_code = bfp_pkg::COND_RETRIP;
    end else if (running) begin
      cond_code = bfp_pkg::COND_START;
    end else if (pick) begin
      cond_code = bfp_pkg::COND_ON; // pick-up seen, criterion not met
    end else begin
      cond_code = bfp_pkg::COND_NORMAL;
    end
  end

  always_comb begin
    status = 32'h00000000;
    status[bfp_pkg::STS_COND_LSB +: 3] = cond_code;
    status[bfp_pkg::STS_BEH_LSB +: 3] = node_off ? bfp_pkg::MODE_OFF : function_node_mode;
    status[bfp_pkg::STS_START_BIT] = running;
    status[bfp_pkg::STS_RT_BIT] = retrip_r;
    status[bfp_pkg::STS_BF_BIT] = fail_r;
    status[bfp_pkg::STS_BLK_BIT] = state_r == bfp_pkg::ST_BLOCKED;
    status[bfp_pkg::STS_PICK_BIT] = pick;
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [bfp_pkg::CNT_W-1:0] start_ticks_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || !running) begin
      start_ticks_r <= '0;
    end else if (tick && !(&start_ticks_r)) begin
      start_ticks_r <= start_ticks_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence leave_start_s;
    running ##1 !running;
  endsequence
  sequence outs_clear_s;
    !rt_if.expired && !bf_if.expired ##1 !retrip_o && !breaker_failure_output_o;
  endsequence

  start_on_pick_a: assert property (tick && state_r == bfp_pkg::ST_IDLE && cond &&
    !node_off && !eff_blk |=> start_o && !blocked_o) else $error("start not raised");
  block_on_pick_a: assert property (tick && state_r == bfp_pkg::ST_IDLE && cond &&
    !node_off && eff_blk |=> blocked_o ##1 !rt_if.expired) else $error("block ignored");
  start_drop_blk_a: assert property (tick && running && eff_blk |=> !start_o)
    else $error("start kept under block");
  state_at_tick_a: assert property (state_r != $past(state_r) |-> $past(tick))
    else $error("state moved between program cycles");
  retrip_delay_a: assert property ($rose(rt_if.expired) |-> start_ticks_r ==
    ((rt_if.delay == '0) ? 19'h00001 : rt_if.delay)) else $error("retrip delay off");
  fail_delay_a: assert property ($rose(bf_if.expired) |-> start_ticks_r ==
    ((bf_if.delay == '0) ? 19'h00001 : bf_if.delay)) else $error("failure delay off");
  outs_release_a: assert property (leave_start_s |=> outs_clear_s)
    else $error("outputs not cleared together");
  retrip_off_a: assert property (!rt_en [*2] |-> !retrip_o)
    else $error("retrip while disabled");
  cur_halt_a: assert property (tick && crit == bfp_pkg::CRIT_CUR_AND_DO && !do_monitor_i
    |=> !start_o) else $error("counting without relay");
  cur_release_a: assert property (tick && running && crit == bfp_pkg::CRIT_CUR && !pick
    |=> !start_o ##1 !rt_if.expired) else $error("counters kept after drop");
  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule // bfp_top
`default_nettype wire

/* File: sim/bfp_breaker.sv */
`timescale 1ns/100ps
`default_nettype none
module bfp_breaker (
  // clock
  input wire logic clk_i,
  // trip command from the primary stage
  input wire logic trip_i,
  // monitored output relay
  output logic relay_o
);
  // relay pulls in one clock late; a real contact is never faster
  always_ff @(posedge clk_i) begin
    relay_o <= trip_i;
  end
endmodule // bfp_breaker
`default_nettype wire

/* File: sim/bfp_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module bfp_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0, trip = 1'b0, blk = 1'b0, sig = 1'b0;
  logic [15:0] r1 = 16'h0000;
  logic ack, start, bo, rt, bf, relay;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat, rd;
  logic [2:0][15:0] ph = '0;
  int failures = 0, total_checks = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  bfp_top #(.CYCLE_CLKS(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phase_magnitude_i(ph), .residual_input_one_i(r1),
    .residual_input_two_i(16'h0000), .computed_residual_i(16'h0000), .do_monitor_i(relay),
    .signal_monitor_i(sig), .block_i(blk), .start_o(start), .blocked_o(bo), .retrip_o(rt),
    .breaker_failure_output_o(bf));
  bfp_breaker i_brk (.clk_i(clk_i), .trip_i(trip), .relay_o(relay));
  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // request held until ack is sampled high at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  task automatic conclude();
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs();
    rdchk("ctrl", bfp_pkg::ADR_CTRL, 32'h00000040);
    rdchk("ph_thr", bfp_pkg::ADR_PH_THR, 32'h00000014);
    rdchk("res_thr", bfp_pkg::ADR_RES_THR, 32'h000004B0);
    rdchk("rt_dly", bfp_pkg::ADR_RT_DLY, 32'h00000014);
    rdchk("bf_dly", bfp_pkg::ADR_BF_DLY, 32'h00000028);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h3C, 32'h00000000);
  endtask
  // threshold 200 must be exceeded, then both delays run from one start
  task automatic t_current();
    int n = 0;
    ph[1] <= 16'h00C8;
    clks(60);
    chk("at threshold", start, 1'b0);
    ph[1] <= 16'h00C9;
    clks(420);
    chk("retrip early", {start, rt}, 2'b10);
    clks(22);
    chk("retrip", {start, rt, bf}, 3'b110);
    clks(378);
    chk("fail early", bf, 1'b0);
    clks(22);
    chk("fail", bf, 1'b1);
    // 195 sits above the 194 release level
    ph[1] <= 16'h00C3;
    clks(100);
    chk("hold", {start, bf}, 2'b11);
    ph[1] <= 16'h0096;
    // wait for the first contact to open, bounded
    while ({rt, bf} === 2'b11 && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    chk("drop together", {rt, bf}, 2'b00);
    chk("released", {start, rt, bf}, 3'b000);
  endtask
  // block is raised well ahead of any delay expiry
  task automatic t_block();
    ph[0] <= 16'h00C9;
    clks(60);
    chk("start", {start, bo}, 2'b10);
    blk <= 1'b1;
    clks(25);
    chk("start dropped", start, 1'b0);
    clks(45);
    chk("blocked", {start, bo, rt}, 3'b010);
    ph[0] <= 16'h0000;
    clks(60);
    blk <= 1'b0;
    chk("unblocked", bo, 1'b0);
  endtask
  // current and relay, retrip disabled
  task automatic t_do();
    bus(1'b1, bfp_pkg::ADR_CTRL, 32'h0000000C);
    ph[2] <= 16'h01F4;
    clks(60);
    chk("halted", start, 1'b0);
    trip <= 1'b1;
    clks(60);
    chk("relay start", start, 1'b1);
    clks(820);
    chk("no retrip", {rt, bf}, 2'b01);
    trip <= 1'b0;
    clks(60);
    chk("relay drop", {start, bf}, 2'b00);
  endtask
  // first residual input in test mode, then signals only with mode on
  task automatic t_res();
    ph <= '0;
    r1 <= 16'h04B1;
    bus(1'b1, bfp_pkg::ADR_CTRL, 32'h00000241);
    clks(60);
    rdchk("status", bfp_pkg::ADR_STATUS, 32'h00001121);
    clks(440);
    chk("test contacts", {start, rt}, 2'b10);
    r1 <= 16'h0000;
    sig <= 1'b1;
    bus(1'b1, bfp_pkg::ADR_CTRL, 32'h00000048);
    clks(60);
    chk("signal hold", {start, rt}, 2'b11);
    sig <= 1'b0;
    clks(60);
    chk("signal drop", {start, rt}, 2'b00);
  endtask
  // main sequence
  initial begin
    clks(8);
    rst_i <= 1'b0;
    t_regs();
    t_current();
    t_block();
    t_do();
    t_res();
    conclude();
  end
  // watchdog, about twice the expected run
  initial begin
    clks(6000);
    failures++;
    conclude();
  end
endmodule // bfp_top_tb
`default_nettype wire
